//--- core/smon_map.svh
/*
  register offsets, configuration field positions and reset values of the
  monitor's two-wire slave interface.
  assumes it is included by bare name from design files that need them.
*/
`ifndef SMON_MAP_SVH
`define SMON_MAP_SVH

// ==========================================================
// register offsets (command byte values)
`define SMON_REG_TEMP 8'h27
`define SMON_REG_CFG 8'h40
`define SMON_REG_SADDR 8'h41

// ==========================================================
// bus constants
`define SMON_ARA_ADDR 7'h0c
`define SMON_BIT_ACK 4'h8
`define SMON_BIT_END 4'h9

// ==========================================================
// configuration fields
`define SMON_CFG_START 0
`define SMON_CFG_ALERT_EN 1
`define SMON_CFG_ALERT_CLR 3
`define SMON_CFG_LINE50 4
`define SMON_CFG_OSR_LOW 5
`define SMON_CFG_SOFT_RST 7
`define SMON_CFG_RESET 8'h00
`define SMON_CFG_WMASK 8'h3b

`endif

//--- core/smon_pkg.sv
/*
  types shared by the monitor's two-wire slave interface.
  assumes nothing beyond a SystemVerilog compiler.
*/
package smon_pkg;

  // ==========================================================
  // transfer phases, one-hot
  typedef enum logic [4:0]
  {
    SMON_ST_IDLE = 5'h01,
    SMON_ST_ADDR = 5'h02,
    SMON_ST_CMD = 5'h04,
    SMON_ST_WDAT = 5'h08,
    SMON_ST_RDAT = 5'h10
  } smon_state_e;

  // ==========================================================
  // whole state of the slave
  typedef struct packed
  {
    smon_state_e st;
    logic scl;
    logic sda;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rnw;
    logic ara;
    logic nack;
    logic idx;
    logic oe;
    logic [6:0] own;
    logic [7:0] cmd;
    logic [7:0] cfg;
    logic [6:0] ovr;
    logic ovr_v;
    logic [7:0] temp_lo;
    logic soft_rst;
  } smon_state_s;

endpackage

//--- core/smon_addr_sel.sv
/*
  slave address selection: strap decode with software override.
  assumes strap_code is the already sensed state of the address strap pin.
*/
`timescale 1ns/1ps
module smon_addr_sel import smon_pkg::*;
#(
  parameter logic [6:0] ADDR_GND = 7'h18,
  parameter logic [6:0] ADDR_SDA = 7'h19,
  parameter logic [6:0] ADDR_SCL = 7'h1a,
  parameter logic [6:0] ADDR_VCC = 7'h1b
)
(
  // strap and override
  input wire logic [1:0] strap_code,
  input wire logic [6:0] ovr_addr,
  input wire logic ovr_valid,
  // result
  output logic [6:0] eff_addr
);

  // ==========================================================
  // strap decode: 0 gnd, 1 data line, 2 clock line, 3 supply
  function automatic logic [6:0] strap_decode(input logic [1:0] code);
    logic [6:0] a;
    a = ADDR_GND;
    case (code)
      2'h0: a = ADDR_GND;
      2'h1: a = ADDR_SDA;
      2'h2: a = ADDR_SCL;
      2'h3: a = ADDR_VCC;
      default: a = ADDR_GND;
    endcase
    return a;
  endfunction

  assign eff_addr = ovr_valid ? ovr_addr : strap_decode(strap_code);

endmodule

//--- core/smon_slave.sv
/*
  two-wire (SMBus compatible) slave of the temperature and supply monitor:
  byte protocols, address strapping and override, alert response,
  configuration register and temperature readout formats.
  assumes scl_in/sda_in/irq_pending/temp_data are synchronous to core_clk,
  which runs much faster than the bus clock; the pad resolves open drain.
*/
`timescale 1ns/1ps
`include "smon_map.svh"
module smon_slave import smon_pkg::*;
#(
  parameter logic [6:0] ADDR_GND = 7'h18,
  parameter logic [6:0] ADDR_SDA = 7'h19,
  parameter logic [6:0] ADDR_SCL = 7'h1a,
  parameter logic [6:0] ADDR_VCC = 7'h1b
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // alert line, open drain
  output logic alert_out,
  output logic alert_oe,
  // strap and monitor core
  input wire logic [1:0] strap_code,
  input wire logic [10:0] temp_data,
  input wire logic irq_pending,
  output logic monitor_run,
  output logic line_50hz,
  output logic osr_low,
  output logic soft_reset_pulse
);

  // ==========================================================
  // state
  smon_state_s q;
  smon_state_s d;
  logic [6:0] eff_addr;
  logic alert_act;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [7:0] tx_byte;

  smon_addr_sel #(
    .ADDR_GND(ADDR_GND),
    .ADDR_SDA(ADDR_SDA),
    .ADDR_SCL(ADDR_SCL),
    .ADDR_VCC(ADDR_VCC)
  ) smon_addr_sel_i (
    .strap_code(strap_code),
    .ovr_addr(q.ovr),
    .ovr_valid(q.ovr_v),
    .eff_addr(eff_addr)
  );

  // ==========================================================
  // helpers
  function automatic logic [7:0] temp_low(input logic [10:0] t, input logic nine);
    logic [7:0] b;
    b = {t[2:0], 5'h00};
    if (nine)
      b = {t[2], 7'h00};
    return b;
  endfunction

  function automatic logic [7:0] reg_read(input logic [7:0] c, input smon_state_s s,
                                          input logic [10:0] t);
    logic [7:0] r;
    r = 8'h00;
    case (c)
      `SMON_REG_TEMP: r = t[10:3];
      `SMON_REG_CFG: r = s.cfg;
      `SMON_REG_SADDR: r = {1'b0, s.own};
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // ==========================================================
  // outputs
  // alert gated by enable and clear bits; status itself lives outside
  // an alert answer never feeds this gate, so answering cannot clear it
  assign alert_act = irq_pending & q.cfg[`SMON_CFG_ALERT_EN]
                     & ~q.cfg[`SMON_CFG_ALERT_CLR];
  assign alert_oe = alert_act;
  assign alert_out = 1'b0;
  assign sda_out = 1'b0;
  assign sda_oe = q.oe;
  assign monitor_run = q.cfg[`SMON_CFG_START] & ~q.cfg[`SMON_CFG_ALERT_CLR];
  assign line_50hz = q.cfg[`SMON_CFG_LINE50];
  assign osr_low = q.cfg[`SMON_CFG_OSR_LOW];
  assign soft_reset_pulse = q.soft_rst;

  assign rise = scl_in & ~q.scl;
  assign fall = ~scl_in & q.scl;
  assign start = q.scl & scl_in & q.sda & ~sda_in;
  assign stop = q.scl & scl_in & ~q.sda & sda_in;

  // first byte: own address for an alert answer, else the indexed register
  assign tx_byte = q.idx ? ((q.cmd == `SMON_REG_TEMP) ? q.temp_lo : 8'h00)
                 : (q.ara ? {q.own, 1'b0} : reg_read(q.cmd, q, temp_data));

  // ==========================================================
  // next state
  always_comb
  begin
    d = q;
    d.soft_rst = 1'b0;
    d.scl = scl_in;
    d.sda = sda_in;
    if (start)
    begin
      d.st = SMON_ST_ADDR;
      d.bitcnt = 4'h0;
      d.own = eff_addr;
      d.oe = 1'b0;
      d.ara = 1'b0;
      d.idx = 1'b0;
    end
    else if (stop)
    begin
      d.st = SMON_ST_IDLE;
      d.oe = 1'b0;
    end
    else
    begin
      case (q.st)
        SMON_ST_IDLE:
        begin
          d.oe = 1'b0;
        end
        SMON_ST_ADDR, SMON_ST_CMD, SMON_ST_WDAT:
        begin
          if (rise && q.bitcnt < `SMON_BIT_ACK)
          begin
            d.shreg = {q.shreg[6:0], sda_in};
            d.bitcnt = q.bitcnt + 4'h1;
          end
          else if (rise && q.bitcnt == `SMON_BIT_ACK)
            d.bitcnt = `SMON_BIT_END;
          if (fall && q.bitcnt == `SMON_BIT_ACK)
          begin
            d.oe = 1'b1;
            case (q.st)
              SMON_ST_ADDR:
              begin
                d.rnw = q.shreg[0];
                if (q.shreg[7:1] == q.own)
                  d.ara = 1'b0;
                else if (q.shreg[7:1] == `SMON_ARA_ADDR && q.shreg[0] && alert_act)
                  d.ara = 1'b1;
                else
                begin
                  d.oe = 1'b0;
                  d.st = SMON_ST_IDLE;
                end
              end
              SMON_ST_CMD:
                d.cmd = q.shreg;
              default:
              begin
                if (q.cmd == `SMON_REG_CFG)
                begin
                  if (q.shreg[`SMON_CFG_SOFT_RST])
                  begin
                    d.cfg = `SMON_CFG_RESET;
                    d.soft_rst = 1'b1;
                  end
                  else
                    d.cfg = q.shreg & `SMON_CFG_WMASK;
                end
                else if (q.cmd == `SMON_REG_SADDR)
                begin
                  d.ovr = q.shreg[6:0];
                  d.ovr_v = 1'b1;
                end
              end
            endcase
          end
          if (fall && q.bitcnt == `SMON_BIT_END)
          begin
            d.bitcnt = 4'h0;
            d.oe = 1'b0;
            if (q.st == SMON_ST_ADDR && q.rnw)
            begin
              d.st = SMON_ST_RDAT;
              d.shreg = tx_byte;
              d.oe = ~tx_byte[7];
              d.idx = 1'b1;
              d.temp_lo = temp_low(temp_data, q.cfg[`SMON_CFG_OSR_LOW]);
            end
            else if (q.st == SMON_ST_ADDR)
              d.st = SMON_ST_CMD;
            else
              d.st = SMON_ST_WDAT;
          end
        end
        SMON_ST_RDAT:
        begin
          if (rise && q.bitcnt < `SMON_BIT_ACK)
          begin
            if (q.ara && !q.oe && !sda_in)
            begin
              // lost to a lower address: drop off, alert untouched
              d.st = SMON_ST_IDLE;
              d.oe = 1'b0;
            end
            else
            begin
              d.shreg = {q.shreg[6:0], 1'b1};
              d.bitcnt = q.bitcnt + 4'h1;
            end
          end
          else if (rise && q.bitcnt == `SMON_BIT_ACK)
          begin
            d.nack = sda_in;
            d.bitcnt = `SMON_BIT_END;
          end
          if (fall && q.bitcnt != 4'h0 && q.bitcnt < `SMON_BIT_ACK)
            d.oe = ~q.shreg[7];
          else if (fall && q.bitcnt == `SMON_BIT_ACK)
            d.oe = 1'b0;
          else if (fall && q.bitcnt == `SMON_BIT_END)
          begin
            d.bitcnt = 4'h0;
            if (q.nack)
            begin
              d.st = SMON_ST_IDLE;
              d.oe = 1'b0;
            end
            else
            begin
              d.shreg = tx_byte;
              d.oe = ~tx_byte[7];
            end
          end
        end
        default:
        begin
          d.st = SMON_ST_IDLE;
          d.oe = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      q <= '{st: SMON_ST_IDLE, scl: 1'b1, sda: 1'b1, bitcnt: 4'h0, shreg: 8'h00,
             rnw: 1'b0, ara: 1'b0, nack: 1'b0, idx: 1'b0, oe: 1'b0, own: 7'h00,
             cmd: 8'h00, cfg: `SMON_CFG_RESET, ovr: 7'h00, ovr_v: 1'b0,
             temp_lo: 8'h00, soft_rst: 1'b0};
    end
    else
      q <= d;
  end

  // ==========================================================
  // checks
  sequence cfg_write_s;
    q.st == SMON_ST_WDAT && fall && q.bitcnt == `SMON_BIT_ACK && q.cmd == `SMON_REG_CFG;
  endsequence

  sequence ara_answer_s;
    q.st == SMON_ST_ADDR && fall && q.bitcnt == `SMON_BIT_ACK && !start && !stop
    && q.shreg == {`SMON_ARA_ADDR, 1'b1} && q.shreg[7:1] != q.own;
  endsequence

  soft_reset_a: assert property (@(posedge core_clk) disable iff (reset)
    cfg_write_s and (q.shreg[7] && !start && !stop)
    |=> q.cfg == `SMON_CFG_RESET && soft_reset_pulse ##1 !soft_reset_pulse)
    else $error("config soft reset did not restore default");

  cfg_store_a: assert property (@(posedge core_clk) disable iff (reset)
    cfg_write_s and (!q.shreg[7] && !start && !stop)
    |=> q.cfg == ($past(q.shreg) & `SMON_CFG_WMASK))
    else $error("config write not stored");

  alert_gate_a: assert property (@(posedge core_clk) disable iff (reset)
    alert_oe |-> q.cfg[1] && !q.cfg[3] && irq_pending)
    else $error("alert driven while disabled or cleared");

  alert_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    q.cfg[3] |-> !alert_oe && !monitor_run)
    else $error("clear bit did not silence alert and loop");

  strap_latch_a: assert property (@(posedge core_clk) disable iff (reset)
    start |=> q.own == $past(eff_addr) && q.st == SMON_ST_ADDR)
    else $error("address not sampled at start");

  ara_ack_a: assert property (@(posedge core_clk) disable iff (reset)
    ara_answer_s and (alert_act) |=> q.ara && q.oe)
    else $error("alert response not acknowledged");

  ara_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    q.ara && alert_act && $stable(irq_pending) && $stable(q.cfg) |=> alert_oe)
    else $error("alert dropped by alert response");

  arb_lost_a: assert property (@(posedge core_clk) disable iff (reset)
    q.st == SMON_ST_RDAT && q.ara && rise && !q.oe && !sda_in && !start && !stop
    && q.bitcnt < 4'h8 |=> q.st == SMON_ST_IDLE && !sda_oe)
    else $error("arbitration loss not handled");

  temp_fmt_a: assert property (@(posedge core_clk) disable iff (reset)
    q.st == SMON_ST_ADDR && q.rnw && fall && q.bitcnt == 4'h9 && !start && !stop
    |=> q.temp_lo[4:0] == 5'h00 && (!q.cfg[5] || q.temp_lo[6:0] == 7'h00))
    else $error("temperature low byte format wrong");

  ovr_addr_a: assert property (@(posedge core_clk) disable iff (reset)
    q.ovr_v |-> eff_addr == q.ovr ##1 q.ovr_v)
    else $error("address override lost");

endmodule

//--- verification/smon_host_model.sv
/*
  smbus host master model for the monitor slave, with one rival slave
  that can answer an alert response.
  assumes sda_line is the resolved wired-and data line.
*/
`timescale 1ns/1ps
module smon_host_model
(
  // clock
  input wire logic core_clk,
  // bus
  input wire logic sda_line,
  output logic scl,
  output logic sda,
  output logic rival_sda
);
  logic rival_on;
  logic [7:0] rival_byte;
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
    rival_sda = 1'b1;
    rival_on = 1'b0;
    rival_byte = 8'hff;
  end
  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // ==========================================================
  // bus conditions; scl stays still between frames
  task automatic start_c();
    sda = 1'b1;
    w(3);
    scl = 1'b1;
    w(5);
    sda = 1'b0;
    w(5);
    scl = 1'b0;
    w(2);
  endtask
  task automatic stop_c();
    sda = 1'b0;
    w(3);
    scl = 1'b1;
    w(5);
    sda = 1'b1;
    w(5);
  endtask
  // ==========================================================
  // bits and bytes, msb first; phases of 5 clocks exceed the slave minimum
  task automatic bitw(input logic b);
    sda = b;
    w(3);
    scl = 1'b1;
    w(5);
    scl = 1'b0;
    w(2);
  endtask
  // rival drives its bit like a slave would, released afterwards
  task automatic bitr(input logic r, output logic b);
    sda = 1'b1;
    rival_sda = r;
    w(3);
    scl = 1'b1;
    w(3);
    b = sda_line;
    w(2);
    scl = 1'b0;
    w(1);
    rival_sda = 1'b1;
    w(1);
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--)
      bitw(v[i]);
    bitr(1'b1, x);
    ack = ~x;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      bitr(rival_on ? rival_byte[i] : 1'b1, b[i]);
    bitw(last);
  endtask
endmodule

//--- verification/smon_slave_tb.sv
/*
  self-checking bench of the monitor slave against expected values computed in the bench.
  assumes the slave's default strap addresses and the host model.
*/
`timescale 1ns/1ps
module smon_slave_tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] strap_code = 2'h0;
  logic [10:0] temp_data = 11'h000;
  logic irq_pending = 1'b0;
  logic scl, hsda, rsda, sda_in, sda_out, sda_oe, alert_out, alert_oe;
  logic monitor_run, line_50hz, osr_low, soft_reset_pulse;
  int bad_count = 0;
  int n_tests = 0;
  int pulses = 0;
  logic [31:0] seed = 32'h0000d843;
  logic [6:0] adr [4] = '{7'h18, 7'h19, 7'h1a, 7'h1b};
  logic [6:0] own_e;
  logic [7:0] cfg_e, v, b;
  logic [15:0] r;
  logic k;
  always #10 core_clk = ~core_clk;
  assign sda_in = hsda & rsda & (sda_oe ? sda_out : 1'b1);
  always @(posedge core_clk)
    if (soft_reset_pulse === 1'b1)
      pulses++;
  smon_slave smon_slave_i (.core_clk(core_clk), .reset(reset), .scl_in(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe),
    .strap_code(strap_code), .temp_data(temp_data), .irq_pending(irq_pending),
    .monitor_run(monitor_run), .line_50hz(line_50hz), .osr_low(osr_low),
    .soft_reset_pulse(soft_reset_pulse));
  smon_host_model smon_host_model_i (.core_clk(core_clk), .sda_line(sda_in), .scl(scl),
    .sda(hsda), .rival_sda(rsda));
  // ==========================================================
  // helpers
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // write byte; the address acknowledge is compared with ea
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input logic ea);
    logic x;
    smon_host_model_i.start_c();
    smon_host_model_i.wbyte({a, 1'b0}, x);
    check(x, ea);
    if (x)
    begin
      smon_host_model_i.wbyte(c, x);
      smon_host_model_i.wbyte(d, x);
    end
    smon_host_model_i.stop_c();
  endtask
  // read byte (n = 1) or read word (n = 2)
  task automatic rd(input logic [6:0] a, input logic [7:0] c, input int n, output logic [15:0] q);
    logic x;
    logic [7:0] b0, b1;
    smon_host_model_i.start_c();
    smon_host_model_i.wbyte({a, 1'b0}, x);
    smon_host_model_i.wbyte(c, x);
    smon_host_model_i.start_c();
    smon_host_model_i.wbyte({a, 1'b1}, x);
    smon_host_model_i.rbyte(n == 1, b0);
    b1 = 8'h00;
    if (n == 2)
      smon_host_model_i.rbyte(1'b1, b1);
    smon_host_model_i.stop_c();
    q = (n == 2) ? {b0, b1} : {8'h00, b0};
  endtask
  // receive byte to address a; ack reported in x
  task automatic rcv(input logic [6:0] a, output logic x, output logic [7:0] q);
    smon_host_model_i.start_c();
    smon_host_model_i.wbyte({a, 1'b1}, x);
    q = 8'hff;
    if (x)
      smon_host_model_i.rbyte(1'b1, q);
    smon_host_model_i.stop_c();
  endtask
  initial
  begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    test_done();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    smon_host_model_i.w(3);
    check({sda_out, alert_out, sda_oe, alert_oe, monitor_run, line_50hz, osr_low}, 16'h0000);
    for (int s = 0; s < 4; s++)
    begin
      strap_code = 2'(s);
      for (int a = 0; a < 4; a++)
        wr(adr[a], 8'h40, 8'h00, a == s);
    end
    strap_code = 2'h0;
    own_e = 7'h18;
    for (int i = 0; i < 4; i++)
    begin
      v = 8'(rnd()) & 8'h7f;
      irq_pending = 1'(rnd());
      // no limit registers live here, so monitoring may start at once
      wr(own_e, 8'h40, v, 1'b1);
      cfg_e = v & 8'h3b;
      rd(own_e, 8'h40, 1, r);
      check(r, {8'h00, cfg_e});
      check(monitor_run, cfg_e[0] & ~cfg_e[3]);
      check(alert_oe, irq_pending & cfg_e[1] & ~cfg_e[3]);
      check({osr_low, line_50hz}, cfg_e[5:4]);
    end
    wr(own_e, 8'h40, 8'h0b, 1'b1);
    irq_pending = 1'b1;
    check({alert_oe, monitor_run}, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      temp_data = 11'(rnd());
      wr(own_e, 8'h40, 8'(i[0]) << 5, 1'b1);
      rd(own_e, 8'h27, 1, r);
      check(r, {8'h00, temp_data[10:3]});
      rd(own_e, 8'h27, 2, r);
      check(r, {temp_data[10:3], i[0] ? {temp_data[2], 7'h00} : {temp_data[2:0], 5'h00}});
    end
    smon_host_model_i.start_c();
    smon_host_model_i.wbyte({own_e, 1'b0}, k);
    smon_host_model_i.wbyte(8'h40, k);
    smon_host_model_i.stop_c();
    rcv(own_e, k, b);
    check({k, b}, 16'h0120);
    rd(own_e, 8'h20, 1, r);
    check(r, 16'h0000);
    wr(own_e, 8'h40, 8'h93, 1'b1);
    rd(own_e, 8'h40, 1, r);
    check({pulses[7:0], r[7:0]}, 16'h0100);
    wr(own_e, 8'h41, 8'h2a, 1'b1);
    own_e = 7'h2a;
    strap_code = 2'h3;
    wr(7'h1b, 8'h40, 8'h00, 1'b0);
    rd(own_e, 8'h41, 1, r);
    check(r, 16'h002a);
    // alert response: once alone, once against a lower rival
    wr(own_e, 8'h40, 8'h02, 1'b1);
    rcv(7'h0c, k, b);
    check({k, b}, {8'h01, own_e, 1'b0});
    check(alert_oe, 16'h0001);
    smon_host_model_i.rival_on = 1'b1;
    smon_host_model_i.rival_byte = 8'h1e;
    rcv(7'h0c, k, b);
    smon_host_model_i.rival_on = 1'b0;
    check({k, b}, 16'h011e);
    check(alert_oe, 16'h0001);
    wr(own_e, 8'h40, 8'h00, 1'b1);
    check(alert_oe, 16'h0000);
    rcv(7'h0c, k, b);
    check(k, 16'h0000);
    // power-on reset again: the strapped address must come back
    @(negedge core_clk);
    reset = 1'b1;
    smon_host_model_i.w(3);
    reset = 1'b0;
    smon_host_model_i.w(3);
    check({sda_oe, alert_oe, monitor_run}, 16'h0000);
    rd(7'h1b, 8'h41, 1, r);
    check(r, 16'h001b);
    test_done();
  end
endmodule
